//--- pfdb_pkg.sv
// Purpose: Constants for the PWM force and dead-band output stage
// Assumes: APB register map, 32-bit data, one word per register
// Notes: All reset values are zero

package pfdb_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] HOLD_FORCE_OFS = 8'h00;
    localparam logic [7:0] DEADBAND_CFG_OFS = 8'h04;
    localparam logic [7:0] RISE_LAG_OFS = 8'h08;
    localparam logic [7:0] FALL_LAG_OFS = 8'h0C;
    localparam logic [7:0] RELOAD_SEL_OFS = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FORCE_A_LSB = 0;
    localparam int FORCE_B_LSB = 2;
    localparam int FORCE_WIDTH = 4;
    localparam int OUT_MODE_LSB = 0;
    localparam int INVERT_LSB = 2;
    localparam int IN_SRC_LSB = 4;
    localparam int DB_CFG_WIDTH = 6;
    localparam int LAG_WIDTH = 10;
    localparam int RELOAD_SEL_LSB = 6;

    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [1:0] FORCE_LOW = 2'h1;
    localparam logic [1:0] FORCE_HIGH = 2'h2;
    localparam logic [1:0] RELOAD_AT_ZERO = 2'h0;
    localparam logic [1:0] RELOAD_AT_PERIOD = 2'h1;
    localparam logic [1:0] RELOAD_AT_EITHER = 2'h2;
    localparam logic [1:0] RELOAD_DIRECT = 2'h3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] HOLD_FORCE_RST = 4'h0;
    localparam logic [5:0] DEADBAND_CFG_RST = 6'h00;
    localparam logic [9:0] LAG_RST = 10'h000;
    localparam logic [1:0] RELOAD_SEL_RST = 2'h0;

endpackage : pfdb_pkg

//--- pfdb_stage.sv
// Purpose: Continuous software force and dead-band stage of one PWM channel pair
// Assumes: pclk is the time-base clock; aq_a, aq_b, ctr_zero, ctr_period are pclk logic
// Notes: Outputs lag the forced/delayed signals by one registered stage
//
// Notes on behaviour
// - Force field for output B at bits 3-2: 01 holds it low, 10 high, 00 and 11 no force.
// - Force field for output A at bits 1-0: 01 holds it low, 10 high, 00 and 11 no force.
// - In immediate mode a written force setting acts at the next clock edge.
// - In shadow mode a force setting acts only at the edge after the shadow load.
// - Reload selector: 00 load at zero, 01 at period, 10 at either, 11 direct write.
// - Input-source field at bits 5-4 chooses A or B for the rising and falling delays.
// - Invert field at bits 3-2: 00 none, 01 output A, 10 output B, 11 both.
// - Output mode 00 passes both signals unchanged, ignoring source and invert fields.
// - Output mode 01 passes A straight and drives B with the falling-delayed signal.
// - Output mode 10 drives A with the rising-delayed signal and passes B straight.
// - Output mode 11 drives A rising-delayed and B falling-delayed.
// - Rising delay count is 10 bits at 9-0, upper bits reserved.
// - Falling delay count is 10 bits at 9-0, bits 31-10 reserved.

module pfdb_stage
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Action-qualifier side
    input wire logic aq_a,
    input wire logic aq_b,
    input wire logic ctr_zero,
    input wire logic ctr_period,
    // Chopper side
    output logic pwm_out_a,
    output logic pwm_out_b
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == pfdb_pkg::HOLD_FORCE_OFS) || (a == pfdb_pkg::DEADBAND_CFG_OFS) ||
                   (a == pfdb_pkg::RISE_LAG_OFS) || (a == pfdb_pkg::FALL_LAG_OFS) ||
                   (a == pfdb_pkg::RELOAD_SEL_OFS);
    endfunction

    function automatic logic apply_force(input logic [1:0] code, input logic sig);
        if (code == pfdb_pkg::FORCE_LOW)
        begin
            apply_force = 1'b0;
        end
        else if (code == pfdb_pkg::FORCE_HIGH)
        begin
            apply_force = 1'b1;
        end
        else
        begin
            apply_force = sig;
        end
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    logic [3:0] force_active;
    logic [3:0] force_shadow;
    logic [1:0] hold_force_reload_sel;
    logic [5:0] deadband_config;
    logic [9:0] rise_lag_count;
    logic [9:0] fall_lag_count;
    logic [31:0] rdata;
    logic [3:0] next_force_active;
    logic [3:0] next_force_shadow;
    logic [1:0] next_reload_sel;
    logic [5:0] next_deadband_config;
    logic [9:0] next_rise_lag;
    logic [9:0] next_fall_lag;
    logic [31:0] next_rdata;
    logic wr_en;
    logic load_evt;

    assign wr_en = psel && penable && pwrite && addr_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata = rdata;

    always_comb
    begin
        next_force_active = force_active;
        next_force_shadow = force_shadow;
        next_reload_sel = hold_force_reload_sel;
        next_deadband_config = deadband_config;
        next_rise_lag = rise_lag_count;
        next_fall_lag = fall_lag_count;
        next_rdata = rdata;
        unique case (hold_force_reload_sel)
            pfdb_pkg::RELOAD_AT_ZERO: load_evt = ctr_zero;
            pfdb_pkg::RELOAD_AT_PERIOD: load_evt = ctr_period;
            pfdb_pkg::RELOAD_AT_EITHER: load_evt = ctr_zero || ctr_period;
            pfdb_pkg::RELOAD_DIRECT: load_evt = 1'b0;
        endcase
        if (load_evt)
        begin
            next_force_active = force_shadow;
        end
        if (wr_en)
        begin
            unique case (paddr)
                pfdb_pkg::HOLD_FORCE_OFS:
                begin
                    // Bits above the two force fields are dropped
                    next_force_shadow = pwdata[pfdb_pkg::FORCE_WIDTH-1:0];
                    if (hold_force_reload_sel == pfdb_pkg::RELOAD_DIRECT)
                    begin
                        next_force_active = pwdata[pfdb_pkg::FORCE_WIDTH-1:0];
                    end
                end
                pfdb_pkg::DEADBAND_CFG_OFS:
                    next_deadband_config = pwdata[pfdb_pkg::DB_CFG_WIDTH-1:0];
                pfdb_pkg::RISE_LAG_OFS:
                    next_rise_lag = pwdata[pfdb_pkg::LAG_WIDTH-1:0];
                pfdb_pkg::FALL_LAG_OFS:
                    next_fall_lag = pwdata[pfdb_pkg::LAG_WIDTH-1:0];
                default:
                    next_reload_sel = pwdata[pfdb_pkg::RELOAD_SEL_LSB +: 2];
            endcase
        end
        // Read data is captured in the setup phase so prdata comes from a flop
        if (psel && !penable)
        begin
            next_rdata = 32'h0000_0000;
            unique case (paddr)
                pfdb_pkg::HOLD_FORCE_OFS: next_rdata[3:0] = force_active;
                pfdb_pkg::DEADBAND_CFG_OFS: next_rdata[5:0] = deadband_config;
                pfdb_pkg::RISE_LAG_OFS: next_rdata[9:0] = rise_lag_count;
                pfdb_pkg::FALL_LAG_OFS: next_rdata[9:0] = fall_lag_count;
                pfdb_pkg::RELOAD_SEL_OFS:
                    next_rdata[pfdb_pkg::RELOAD_SEL_LSB +: 2] = hold_force_reload_sel;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            force_active <= pfdb_pkg::HOLD_FORCE_RST;
            force_shadow <= pfdb_pkg::HOLD_FORCE_RST;
            hold_force_reload_sel <= pfdb_pkg::RELOAD_SEL_RST;
            deadband_config <= pfdb_pkg::DEADBAND_CFG_RST;
            rise_lag_count <= pfdb_pkg::LAG_RST;
            fall_lag_count <= pfdb_pkg::LAG_RST;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            force_active <= next_force_active;
            force_shadow <= next_force_shadow;
            hold_force_reload_sel <= next_reload_sel;
            deadband_config <= next_deadband_config;
            rise_lag_count <= next_rise_lag;
            fall_lag_count <= next_fall_lag;
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Continuous force
    // ****************************************
    logic forced_a;
    logic forced_b;

    assign forced_a = apply_force(force_active[pfdb_pkg::FORCE_A_LSB +: 2], aq_a);
    assign forced_b = apply_force(force_active[pfdb_pkg::FORCE_B_LSB +: 2], aq_b);

    // ****************************************
    // Delay lines
    // ****************************************
    logic [1:0] out_mode;
    logic [1:0] invert_sel;
    logic [1:0] in_src;
    logic rise_src;
    logic fall_src;
    logic [1:0] line_in;
    logic [1:0] line_out;
    logic [9:0] line_lag [2];
    logic rise_dly;
    logic fall_dly;

    assign out_mode = deadband_config[pfdb_pkg::OUT_MODE_LSB +: 2];
    assign invert_sel = deadband_config[pfdb_pkg::INVERT_LSB +: 2];
    assign in_src = deadband_config[pfdb_pkg::IN_SRC_LSB +: 2];
    assign rise_src = in_src[0] ? forced_b : forced_a;
    assign fall_src = in_src[1] ? forced_b : forced_a;
    // Falling delay is a rising delay on the inverted source
    assign line_in = {!fall_src, rise_src};
    assign line_lag[0] = rise_lag_count;
    assign line_lag[1] = fall_lag_count;
    assign rise_dly = line_out[0];
    assign fall_dly = !line_out[1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_line
            logic [9:0] cnt;
            logic [9:0] next_cnt;
            // Saturating compare keeps a shortened count from wrapping the counter
            assign line_out[gi] = line_in[gi] && (cnt >= line_lag[gi]);
            always_comb
            begin
                next_cnt = 10'h000;
                if (line_in[gi] && (cnt < line_lag[gi]))
                begin
                    next_cnt = cnt + 10'h001;
                end
                else if (line_in[gi])
                begin
                    next_cnt = cnt;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt <= pfdb_pkg::LAG_RST;
                end
                else
                begin
                    cnt <= next_cnt;
                end
            end
        end
    endgenerate

    // ****************************************
    // Output select and polarity
    // ****************************************
    logic next_out_a;
    logic next_out_b;

    always_comb
    begin
        next_out_a = out_mode[1] ? (rise_dly ^ invert_sel[0]) : forced_a;
        next_out_b = out_mode[0] ? (fall_dly ^ invert_sel[1]) : forced_b;
        if (out_mode == 2'h0)
        begin
            next_out_a = forced_a;
            next_out_b = forced_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_out_a <= 1'b0;
            pwm_out_b <= 1'b0;
        end
        else
        begin
            pwm_out_a <= next_out_a;
            pwm_out_b <= next_out_b;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_force_b_low: assert property (@(posedge pclk) disable iff (!presetn)
        (force_active[3:2] == 2'h1 && out_mode == 2'h0) |=> !pwm_out_b)
        else $error("output B not held low by force");

    chk_force_a_high: assert property (@(posedge pclk) disable iff (!presetn)
        (force_active[1:0] == 2'h2 && out_mode == 2'h0) |=> pwm_out_a)
        else $error("output A not held high by force");

    chk_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == pfdb_pkg::HOLD_FORCE_OFS
        && hold_force_reload_sel == pfdb_pkg::RELOAD_DIRECT)
        |=> force_active == $past(pwdata[3:0]))
        else $error("direct force write not applied");

    chk_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (hold_force_reload_sel != 2'h3 && !load_evt) |=> $stable(force_active))
        else $error("active force changed without a shadow load");

    chk_zero_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (hold_force_reload_sel == 2'h0 && ctr_zero) |=> force_active == $past(force_shadow))
        else $error("shadow not loaded at counter zero");

    chk_bypass_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (out_mode == 2'h0 && force_active == 4'h0) |=> pwm_out_a == $past(aq_a)
        && pwm_out_b == $past(aq_b))
        else $error("bypass mode altered the signals");

    chk_rise_delay: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(rise_src) && rise_lag_count == 10'h002)
        ##1 (rise_src && rise_lag_count == 10'h002)[*2] |-> rise_dly && !$past(rise_dly))
        else $error("rising delay not two cycles");

    chk_fall_pass: assert property (@(posedge pclk) disable iff (!presetn)
        fall_src |-> fall_dly)
        else $error("falling-delay path blocked a high source");

    chk_invert_both: assert property (@(posedge pclk) disable iff (!presetn)
        (deadband_config[3:0] == 4'hF) |=> pwm_out_a == !$past(rise_dly)
        && pwm_out_b == !$past(fall_dly))
        else $error("inversion not applied to both outputs");

    chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr > pfdb_pkg::RELOAD_SEL_OFS) |-> pslverr)
        else $error("unmapped address not flagged");

endmodule // pfdb_stage

//--- pfdb_aq_model.sv
// Purpose: Upstream action-qualifier and time-base model driving the stage inputs
// Assumes: Callers enter the tasks right after a rising pclk edge
// Notes: Outputs start at zero by blocking assignment, then change by non-blocking assignment at the edge

module pfdb_aq_model
(
    // Clock
    input wire logic pclk,
    // Qualified signals and time-base pulses
    output logic aq_a,
    output logic aq_b,
    output logic ctr_zero,
    output logic ctr_period
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        aq_a = 1'b0;
        aq_b = 1'b0;
        ctr_zero = 1'b0;
        ctr_period = 1'b0;
    end

    task automatic set_aq(input logic a, input logic b);
        aq_a <= a;
        aq_b <= b;
    endtask

    // Time-base events last exactly one cycle, as the real counter gives them
    task automatic pulse(input logic z, input logic p);
        ctr_zero <= z;
        ctr_period <= p;
        @(posedge pclk);
        ctr_zero <= 1'b0;
        ctr_period <= 1'b0;
    endtask
endmodule // pfdb_aq_model

//--- pfdb_stage_tb.sv
// Purpose: Self-checking bench for the force and dead-band stage
// Assumes: Zero-wait APB slave; outputs sampled at the edge, before its updates land
// Notes: Lags kept short so every delay settles within a few cycles

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module pfdb_stage_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic aq_a, aq_b, ctr_zero, ctr_period, pwm_out_a, pwm_out_b, e, ea, eb, sr, sf;
    int n_fail = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int ka, kb;

    pfdb_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aq_a(aq_a), .aq_b(aq_b), .ctr_zero(ctr_zero),
        .ctr_period(ctr_period), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));
    pfdb_aq_model u_aq (.pclk(pclk), .aq_a(aq_a), .aq_b(aq_b), .ctr_zero(ctr_zero),
        .ctr_period(ctr_period));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Whole run needs a few thousand cycles; a hang ends here
    always @(posedge pclk)
    begin
        n_cyc++;
        if (n_cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // Idle edge before the next setup, so psel is never set twice at one edge
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("prdata", ex, q)
        `CHK("pslverr", ee, e)
        `CHK("pready", 1'b1, pready)
    endtask

    task automatic lat(input logic a, input logic ta, input logic tb_);
        ka = 0;
        kb = 0;
        u_aq.set_aq(a, 1'b0);
        for (int k = 1; k <= 20; k++)
        begin
            @(posedge pclk);
            if (ka == 0 && pwm_out_a === ta) ka = k;
            if (kb == 0 && pwm_out_b === tb_) kb = k;
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // ****************************************
        // Reset values, field widths, unmapped place
        // ****************************************
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000, 1'b0);
        rd(8'h14, 32'h0000_0000, 1'b1);
        apb(1'b1, pfdb_pkg::RELOAD_SEL_OFS, 32'hFFFF_FFFF);
        rd(pfdb_pkg::RELOAD_SEL_OFS, 32'h0000_00C0, 1'b0);
        apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'hFFFF_FFFF);
        rd(pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_000F, 1'b0);
        apb(1'b1, pfdb_pkg::DEADBAND_CFG_OFS, 32'hFFFF_FFFF);
        rd(pfdb_pkg::DEADBAND_CFG_OFS, 32'h0000_003F, 1'b0);
        apb(1'b1, pfdb_pkg::RISE_LAG_OFS, 32'hFFFF_FFFF);
        rd(pfdb_pkg::RISE_LAG_OFS, 32'h0000_03FF, 1'b0);
        apb(1'b1, pfdb_pkg::FALL_LAG_OFS, 32'hFFFF_FFFF);
        rd(pfdb_pkg::FALL_LAG_OFS, 32'h0000_03FF, 1'b0);
        apb(1'b1, pfdb_pkg::DEADBAND_CFG_OFS, 32'h0000_0000);
        // ****************************************
        // Force codes in direct mode, pass-through path
        // ****************************************
        for (int s = 0; s < 2; s++)
            for (int f = 0; f < 16; f++)
            begin
                u_aq.set_aq(s[0], s[0]);
                apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'(f));
                repeat (3) @(posedge pclk);
                ea = (f[1:0] == 2'h1) ? 1'b0 : (f[1:0] == 2'h2) ? 1'b1 : s[0];
                eb = (f[3:2] == 2'h1) ? 1'b0 : (f[3:2] == 2'h2) ? 1'b1 : s[0];
                `CHK("force a", ea, pwm_out_a)
                `CHK("force b", eb, pwm_out_b)
            end
        u_aq.set_aq(1'b0, 1'b0);
        apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_0002);
        `CHK("immediate early", 1'b0, pwm_out_a)
        @(posedge pclk);
        `CHK("immediate", 1'b1, pwm_out_a)
        // ****************************************
        // Shadow reload on each selectable event
        // ****************************************
        for (int r = 0; r < 3; r++)
        begin
            apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_0000);
            apb(1'b1, pfdb_pkg::RELOAD_SEL_OFS, 32'(r << 6));
            apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_0002);
            repeat (3) @(posedge pclk);
            `CHK("shadow held", 1'b0, pwm_out_a)
            u_aq.pulse(1'b1, 1'b0);
            repeat (2) @(posedge pclk);
            `CHK("load at zero", (r != 1), pwm_out_a)
            u_aq.pulse(1'b0, 1'b1);
            repeat (2) @(posedge pclk);
            `CHK("load at period", 1'b1, pwm_out_a)
            apb(1'b1, pfdb_pkg::HOLD_FORCE_OFS, 32'h0000_0000);
            u_aq.pulse(1'b1, 1'b1);
            repeat (2) @(posedge pclk);
            `CHK("shadow clear", 1'b0, pwm_out_a)
        end
        // ****************************************
        // Every dead-band setting, settled levels
        // ****************************************
        apb(1'b1, pfdb_pkg::RISE_LAG_OFS, 32'h0000_0005);
        apb(1'b1, pfdb_pkg::FALL_LAG_OFS, 32'h0000_0003);
        for (int c = 0; c < 64; c++)
        begin
            apb(1'b1, pfdb_pkg::DEADBAND_CFG_OFS, 32'(c));
            for (int v = 0; v < 4; v++)
            begin
                u_aq.set_aq(v[0], v[1]);
                repeat (9) @(posedge pclk);
                sr = c[4] ? v[1] : v[0];
                sf = c[5] ? v[1] : v[0];
                ea = c[1] ? sr ^ c[2] : v[0];
                eb = c[0] ? sf ^ c[3] : v[1];
                `CHK("path a", ea, pwm_out_a)
                `CHK("path b", eb, pwm_out_b)
            end
        end
        // ****************************************
        // Edge delays; seen one edge after they are registered
        // ****************************************
        apb(1'b1, pfdb_pkg::DEADBAND_CFG_OFS, 32'h0000_0003);
        u_aq.set_aq(1'b0, 1'b0);
        repeat (10) @(posedge pclk);
        lat(1'b1, 1'b1, 1'b1);
        `CHK("rise lag", 7, ka)
        `CHK("rise on fall path", 2, kb)
        lat(1'b0, 1'b0, 1'b0);
        `CHK("fall on rise path", 2, ka)
        `CHK("fall lag", 5, kb)
        apb(1'b1, pfdb_pkg::RISE_LAG_OFS, 32'h0000_0000);
        lat(1'b1, 1'b1, 1'b1);
        `CHK("zero lag", 2, ka)
        apb(1'b1, pfdb_pkg::RISE_LAG_OFS, 32'h0000_0002);
        lat(1'b0, 1'b0, 1'b0);
        lat(1'b1, 1'b1, 1'b1);
        `CHK("two lag", 4, ka)
        finish_test();
    end
endmodule // pfdb_stage_tb
